// ### rtl/ocs_config.sv
// Purpose: Reset-time option loader for clock source and pin sharing
// Assumes: Option word stable at pins; reset pin asynchronous to clock
// Notes: Selection holds until the next reset
`timescale 1ns/10ps
module ocs_config
   import ocs_pkg::*;
#(
   parameter int CNT_W = OCS_CNT_W
) (
   // Clock and reset
   input wire logic core_clk_i,
   input wire logic reset_i,
   // External reset pin, active low
   input wire logic reset_pin_n_i,
   // Nonvolatile option word
   input wire logic [OCS_OPT_W-1:0] option_i,
   // Port bit requests from the port block
   input wire logic port_bit_a_out_i,
   input wire logic port_bit_a_oe_i,
   input wire logic port_bit_b_out_i,
   input wire logic port_bit_b_oe_i,
   // Oscillator pins
   input wire logic osc_in_pin_i,
   input wire logic osc_out_pin_i,
   output logic osc_in_pin_o,
   output logic osc_in_pin_oe_o,
   output logic osc_out_pin_o,
   output logic osc_out_pin_oe_o,
   // Port bit inputs back to the port block
   output logic port_bit_a_in_o,
   output logic port_bit_b_in_o,
   // Status
   output logic [1:0] clk_src_o,
   output logic xtal_en_o,
   output logic ext_clk_en_o,
   output logic port_a_avail_o,
   output logic port_b_avail_o,
   output logic reset_pin_mode_select_o,
   output logic sys_reset_o,
   output logic ready_o
);
   // ==========================================================
   // State
   typedef enum {
      S_HOLD,
      S_READ,
      S_WAIT,
      S_RUN
   } ocs_fsm_t;

   typedef struct packed {
      ocs_fsm_t fsm;
      logic [1:0] src;
      logic rmode;
      logic pin_s1;
      logic pin_s2;
      logic a_s1;
      logic a_s2;
      logic b_s1;
      logic b_s2;
      logic a_in;
      logic b_in;
   } ocs_state_t;

   ocs_state_t st;
   ocs_state_t next_st;
   logic tmr_load;
   logic tmr_done;
   logic [CNT_W-1:0] wait_len;
   logic [OCS_WSEL_W-1:0] wsel;

   assign wsel = option_i[OCS_WSEL_LSB +: OCS_WSEL_W];
   assign wait_len = CNT_W'(OCS_WAIT_BASE_CYC) << wsel;

   ocs_wait_timer #(
      .CNT_W(CNT_W)
   ) u_tmr (
      .core_clk_i(core_clk_i),
      .reset_i(reset_i),
      .load_i(tmr_load),
      .len_i(wait_len),
      .done_o(tmr_done)
   );

   // ==========================================================
   // Sequencer
   always_comb begin
      next_st = st;
      tmr_load = 1'b0;
      next_st.pin_s1 = reset_pin_n_i;
      next_st.pin_s2 = st.pin_s1;
      next_st.a_s1 = osc_in_pin_i;
      next_st.a_s2 = st.a_s1;
      next_st.b_s1 = osc_out_pin_i;
      next_st.b_s2 = st.b_s1;
      next_st.a_in = st.a_s2;
      next_st.b_in = st.b_s2;
      case (st.fsm)
         S_HOLD: begin
            if (st.pin_s2) begin
               next_st.fsm = S_READ;
            end
         end
         S_READ: begin
            if (!st.pin_s2) begin
               next_st.fsm = S_HOLD;
            end else begin
               next_st.src = option_i[OCS_SRC_LSB +: 2];
               next_st.rmode = option_i[OCS_RST_LSB];
               if (option_i[OCS_SRC_LSB +: 2] == OCS_SRC_XTAL) begin
                  tmr_load = 1'b1;
                  next_st.fsm = S_WAIT;
               end else begin
                  next_st.fsm = S_RUN;
               end
            end
         end
         S_WAIT: begin
            if (tmr_done) begin
               next_st.fsm = S_RUN;
            end
         end
         S_RUN: begin
         end
         default: begin
            next_st.fsm = S_HOLD;
         end
      endcase
   end

   always_ff @(posedge core_clk_i) begin
      if (reset_i) begin
         st <= '{fsm: S_HOLD, src: OCS_SRC_HIOCO, default: '0};
      end else begin
         st <= next_st;
      end
   end

   // ==========================================================
   // Pin function
   logic is_xtal;
   logic is_ext;
   logic loaded;
   assign loaded = (st.fsm == S_WAIT) || (st.fsm == S_RUN);
   assign is_xtal = loaded && (st.src == OCS_SRC_XTAL);
   assign is_ext = loaded && (st.src == OCS_SRC_EXT);
   assign port_a_avail_o = loaded && !is_xtal && !is_ext;
   assign port_b_avail_o = loaded && !is_xtal;
   assign osc_in_pin_o = port_bit_a_out_i;
   assign osc_in_pin_oe_o = port_a_avail_o && port_bit_a_oe_i;
   assign osc_out_pin_o = port_bit_b_out_i;
   assign osc_out_pin_oe_o = port_b_avail_o && port_bit_b_oe_i;
   assign port_bit_a_in_o = port_a_avail_o ? st.a_in : 1'b0;
   assign port_bit_b_in_o = port_b_avail_o ? st.b_in : 1'b0;
   assign clk_src_o = st.src;
   assign xtal_en_o = is_xtal;
   assign ext_clk_en_o = is_ext;
   assign reset_pin_mode_select_o = st.rmode;
   assign sys_reset_o = (st.fsm != S_RUN);
   assign ready_o = (st.fsm == S_RUN);

   // ==========================================================
   // Checks
   sequence s_capture_xtal;
      st.fsm == S_READ && st.pin_s2 &&
      option_i[OCS_SRC_LSB +: 2] == OCS_SRC_XTAL;
   endsequence

   sequence s_capture_other;
      st.fsm == S_READ && st.pin_s2 &&
      option_i[OCS_SRC_LSB +: 2] != OCS_SRC_XTAL;
   endsequence

   property p_no_wait_other;
      @(posedge core_clk_i) disable iff (reset_i)
      s_capture_other |=> ready_o;
   endproperty
   a_no_wait_other: assert property (p_no_wait_other)
      else $error("wait applied for non-crystal source");

   property p_xtal_wait;
      @(posedge core_clk_i) disable iff (reset_i)
      s_capture_xtal |=> !ready_o [*2];
   endproperty
   a_xtal_wait: assert property (p_xtal_wait)
      else $error("crystal source skipped wait");

   property p_hold_low;
      @(posedge core_clk_i) disable iff (reset_i)
      ((st.fsm == S_HOLD || st.fsm == S_READ) && !st.pin_s2) |=> sys_reset_o;
   endproperty
   a_hold_low: assert property (p_hold_low)
      else $error("reset released while pin low");

   property p_xtal_pins;
      @(posedge core_clk_i) disable iff (reset_i)
      is_xtal |-> !osc_in_pin_oe_o && !osc_out_pin_oe_o && !port_a_avail_o;
   endproperty
   a_xtal_pins: assert property (p_xtal_pins)
      else $error("port active in crystal mode");

   property p_ext_pins;
      @(posedge core_clk_i) disable iff (reset_i)
      is_ext |-> !port_a_avail_o && port_b_avail_o;
   endproperty
   a_ext_pins: assert property (p_ext_pins)
      else $error("pin use wrong in external clock mode");

   property p_int_pins;
      @(posedge core_clk_i) disable iff (reset_i)
      (loaded && st.src == OCS_SRC_HIOCO) |-> port_a_avail_o && port_b_avail_o;
   endproperty
   a_int_pins: assert property (p_int_pins)
      else $error("ports unavailable in internal mode");

   property p_src_held;
      @(posedge core_clk_i) disable iff (reset_i)
      ready_o |=> ready_o && $stable(clk_src_o);
   endproperty
   a_src_held: assert property (p_src_held)
      else $error("source changed after load");
endmodule

// ### rtl/ocs_pkg.sv
// Purpose: Constants for the option clock source and pin configuration
// Assumes: One system clock at 10 MHz, synchronous active-high reset
// Notes: Option word layout and wait length are plain defaults
// Function
// - Apply stabilization wait only when the crystal oscillator is selected.
// - Read option only after reset release; low reset pin holds reset.
// - Oscillator pins share port bits A and B; function follows source.
// - Crystal source: both pins are clock inputs, no port function.
// - External clock: first pin carries clock, port bit A unavailable.
// - Internal oscillator: port bits A and B both usable as ports.
package ocs_pkg;
   // ==========================================================
   // Clock source encoding
   typedef enum logic [1:0] {
      OCS_SRC_XTAL = 2'h0,
      OCS_SRC_EXT = 2'h1,
      OCS_SRC_HIOCO = 2'h2,
      OCS_SRC_RSVD = 2'h3
   } ocs_src_t;
   // ==========================================================
   // Option word layout
   localparam int OCS_OPT_W = 8;
   localparam int OCS_SRC_LSB = 0;
   localparam int OCS_WSEL_LSB = 2;
   localparam int OCS_WSEL_W = 2;
   localparam int OCS_RST_LSB = 7;
   // ==========================================================
   // Timing
   localparam int OCS_CLK_HZ = 10000000;
   localparam int OCS_WAIT_BASE_US = 100;
   localparam int OCS_WAIT_BASE_CYC =
      (OCS_WAIT_BASE_US * (OCS_CLK_HZ / 1000000));
   localparam int OCS_CNT_W = 16;
endpackage

// ### rtl/ocs_wait_timer.sv
// Purpose: Stabilization wait timer
// Assumes: Load pulse starts a count, done level when expired
// Notes: Zero length completes immediately
`timescale 1ns/10ps
module ocs_wait_timer
   import ocs_pkg::*;
#(
   parameter int CNT_W = OCS_CNT_W
) (
   // Clock and reset
   input wire logic core_clk_i,
   input wire logic reset_i,
   // Control
   input wire logic load_i,
   input wire logic [CNT_W-1:0] len_i,
   output logic done_o
);
   typedef struct packed {
      logic [CNT_W-1:0] cnt;
      logic run;
   } ocs_tmr_t;
   ocs_tmr_t st;
   ocs_tmr_t next_st;

   always_comb begin
      next_st = st;
      if (load_i) begin
         next_st.cnt = len_i;
         next_st.run = 1'b1;
      end else if (st.run && st.cnt != '0) begin
         next_st.cnt = st.cnt - 1'b1;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (reset_i) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign done_o = st.run && (st.cnt == '0) && !load_i;
endmodule

// ### testbench/tb.sv
// Purpose: Self-checking bench for the option clock source loader
// Assumes: Option word held steady across each reset release
// Notes: Random option and port values drawn from seed 3
`timescale 1ns/10ps
`define CHK(n, e, s) begin samples_checked++; if ((s) !== (e)) begin \
   mismatches++; $display("unexpected %s exp %h saw %h", n, e, s); end end
module tb;
   import ocs_pkg::*;
   // ==========================================================
   // Signals
   logic core_clk_i = 0;
   logic reset_i = 1;
   logic reset_pin_n_i = 1;
   logic [7:0] option_i = 8'h02;
   logic a_out = 0, a_oe = 0, b_out = 0, b_oe = 0;
   logic in_pin = 0, out_pin = 0;
   logic in_o, in_oe, out_o, out_oe, a_in, b_in, xt, ex, av_a, av_b;
   logic mode, sys_rst, ready_o;
   logic [1:0] clk_src_o;
   int mismatches = 0;
   int samples_checked = 0;
   ocs_config dut (.core_clk_i(core_clk_i), .reset_i(reset_i),
      .reset_pin_n_i(reset_pin_n_i), .option_i(option_i),
      .port_bit_a_out_i(a_out), .port_bit_a_oe_i(a_oe),
      .port_bit_b_out_i(b_out), .port_bit_b_oe_i(b_oe),
      .osc_in_pin_i(in_pin), .osc_out_pin_i(out_pin),
      .osc_in_pin_o(in_o), .osc_in_pin_oe_o(in_oe),
      .osc_out_pin_o(out_o), .osc_out_pin_oe_o(out_oe),
      .port_bit_a_in_o(a_in), .port_bit_b_in_o(b_in),
      .clk_src_o(clk_src_o), .xtal_en_o(xt), .ext_clk_en_o(ex),
      .port_a_avail_o(av_a), .port_b_avail_o(av_b),
      .reset_pin_mode_select_o(mode), .sys_reset_o(sys_rst),
      .ready_o(ready_o));
   initial begin
      forever #50 core_clk_i = ~core_clk_i;
   end
   // ==========================================================
   // Expectations
   function automatic logic [1:0] exp_avail(input logic [1:0] s);
      case (s)
         2'h0: return 2'h0;
         2'h1: return 2'h1;
         default: return 2'h3;
      endcase
   endfunction
   function automatic int exp_wait(input logic [1:0] s,
                                   input logic [1:0] ws);
      return (s == 2'h0) ? (OCS_WAIT_BASE_CYC << ws) : 0;
   endfunction
   task automatic complete_run();
      $display("checks %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   // ==========================================================
   // One reset release with a given source
   task automatic run_one(input logic [1:0] src, input logic [1:0] wsel,
                          input logic late);
      int n;
      int w;
      logic [7:0] opt;
      logic [1:0] av;
      opt = 8'($urandom);
      opt[1:0] = src;
      opt[3:2] = wsel;
      w = exp_wait(src, wsel);
      av = exp_avail(src);
      @(negedge core_clk_i);
      reset_i = 1;
      option_i = opt;
      reset_pin_n_i = !late;
      repeat (10) @(negedge core_clk_i);
      `CHK("reset src", OCS_SRC_HIOCO, clk_src_o)
      `CHK("reset hold", 1'b1, sys_rst)
      `CHK("reset avail", 2'h0, {av_a, av_b})
      reset_i = 0;
      if (late) begin
         repeat (20) @(negedge core_clk_i);
         `CHK("held reset", 1'b1, sys_rst)
         `CHK("held ready", 1'b0, ready_o)
         // One-cycle high pulse reaches READ, then pin low again
         reset_pin_n_i = 1;
         @(negedge core_clk_i);
         reset_pin_n_i = 0;
         repeat (8) @(negedge core_clk_i);
         `CHK("glitch reset", 1'b1, sys_rst)
         `CHK("glitch ready", 1'b0, ready_o)
         reset_pin_n_i = 1;
      end
      n = 0;
      while (ready_o !== 1'b1 && n < 9000) begin
         @(negedge core_clk_i);
         n++;
      end
      if (src == 2'h0) begin
         `CHK("xtal wait", 1'b1, n >= w && n <= w + 8)
      end else begin
         `CHK("no wait", 1'b1, n <= 6)
      end
      `CHK("run reset", 1'b0, sys_rst)
      `CHK("source", src, clk_src_o)
      `CHK("xtal en", src == 2'h0, xt)
      `CHK("ext en", src == 2'h1, ex)
      `CHK("avail", av, {av_a, av_b})
      `CHK("mode", opt[7], mode)
      repeat (3) begin
         {a_out, a_oe, b_out, b_oe, in_pin, out_pin} = 6'($urandom);
         repeat (4) @(negedge core_clk_i);
         `CHK("a oe", av[1] & a_oe, in_oe)
         `CHK("b oe", av[0] & b_oe, out_oe)
         if (av[1]) `CHK("a drive", a_out, in_o)
         if (av[0]) `CHK("b drive", b_out, out_o)
         `CHK("a in", av[1] & in_pin, a_in)
         `CHK("b in", av[0] & out_pin, b_in)
      end
      option_i = ~opt;
      repeat (5) @(negedge core_clk_i);
      `CHK("kept source", src, clk_src_o)
      `CHK("kept avail", av, {av_a, av_b})
      `CHK("kept ready", 1'b1, ready_o)
      `CHK("kept mode", opt[7], mode)
   endtask
   // ==========================================================
   // Main sequence and watchdog
   initial begin
      logic [1:0] s;
      void'($urandom(3));
      for (int i = 0; i < 10; i++) begin
         s = 2'(i % 4);
         run_one(s, (i == 8) ? 2'h3 : 2'($urandom),
                 i == 4 || i == 5);
      end
      complete_run();
   end
   initial begin
      #(100 * 45000);
      mismatches++;
      complete_run();
   end
endmodule
